// file: logic/pack_override_pkg.sv
// constants shared by both ends of the pack host-override link
// What this block does
// - discharge switch bit written directly, resets off
// - discharge overcurrent clears switch bit unless overridden
// - short circuit always forces switches off
// - override register resets zero, top bit reserved
// - switch override hands switch control to host
// - listed faults force switches off regardless
// - balance override stops automatic cell balancing
// - load override stops automatic load monitoring
// - charger override stops automatic charger monitoring
// - scan override stops automatic measurement scans
// - watchdog clears scan override, resume after transaction
// - open-wire trigger starts scan, reads busy
// - open-wire trigger needs detect-disable or scan override
// - balance apply drives masked outputs under override
// - load trigger pulses recovery, updates status, clears
package pack_override_pkg;
  // ----------------------------------------
  // register map of the monitor
  // ----------------------------------------
  localparam logic [7:0] STATUS_ADDR = 8'h82;
  localparam logic [7:0] MASK_ADDR = 8'h84;
  localparam logic [7:0] CONTROL1_ADDR = 8'h86;
  localparam logic [7:0] OVERRIDE_ADDR = 8'h87;
  localparam logic [7:0] OW_CONFIG_ADDR = 8'h4a;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int LOAD_PRESENT_BIT = 0;
  localparam int CHARGER_PRESENT_BIT = 1;
  localparam int DISCHARGE_ON_BIT = 0;
  localparam int CHARGER_TRIG_BIT = 4;
  localparam int LOAD_TRIG_BIT = 6;
  localparam int RESERVED_BIT = 7;
  localparam int SWITCH_OVR_BIT = 6;
  localparam int BALANCE_OVR_BIT = 5;
  localparam int LOAD_OVR_BIT = 4;
  localparam int CHARGER_OVR_BIT = 3;
  localparam int SCAN_OVR_BIT = 2;
  localparam int OW_TRIG_BIT = 1;
  localparam int BALANCE_APPLY_BIT = 0;
  localparam int OW_DISABLE_BIT = 1;
  localparam logic [7:0] RESERVED_MASK = 8'h80;
  // ----------------------------------------
  // controller registers on the axi side
  // ----------------------------------------
  localparam logic [3:0] CMD_OFFSET = 4'h0;
  localparam logic [3:0] STAT_OFFSET = 4'h4;
  localparam int CMD_WRITE_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : pack_override_pkg

// file: logic/pack_link_if.sv
// register link between the host controller and the pack monitor
`timescale 1ns/100ps
interface pack_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport monitor (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface : pack_link_if

// file: logic/pack_override_monitor.sv
// monitor end: host-override control register bank
`timescale 1ns/100ps
module pack_override_monitor
  import pack_override_pkg::*;
#(
  parameter int BAL_CELLS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  pack_link_if.monitor link,
  input wire logic discharge_overcurrent,
  input wire logic discharge_short_circuit,
  input wire logic open_wire_fault,
  input wire logic internal_over_temp,
  input wire logic overvoltage_lockout,
  input wire logic undervoltage_lockout,
  input wire logic sleep_mode,
  input wire logic switches_off_input,
  input wire logic watchdog_expired,
  input wire logic open_wire_scan_done,
  input wire logic load_detect_pin,
  input wire logic charger_detect_pin,
  output logic discharge_switch_gate,
  output logic auto_switch_enable,
  output logic auto_balance_enable,
  output logic auto_load_monitor_enable,
  output logic auto_charger_monitor_enable,
  output logic auto_scan_enable,
  output logic open_wire_scan_start,
  output logic load_recovery_pulse,
  output logic charger_recovery_pulse,
  output logic [BAL_CELLS-1:0] balance_gate_outputs
);
  if (BAL_CELLS < 1 || BAL_CELLS > 8) begin : bad_cells
    $error("BAL_CELLS must be 1 to 8");
  end

  // ----------------------------------------
  // link access
  // ----------------------------------------
  logic take;
  logic wr;
  logic discharge_switch_on;
  logic load_monitor_trigger;
  logic charger_monitor_trigger;
  logic host_switch_override;
  logic host_balance_override;
  logic host_load_monitor_override;
  logic host_charger_monitor_override;
  logic host_scan_override;
  logic open_wire_scan_trigger;
  logic balance_apply;
  logic open_wire_detect_disable;
  logic [7:0] balance_output_mask;
  logic load_present;
  logic charger_present;
  logic scan_hold;
  logic ow_set;
  logic forced_off;
  logic [7:0] next_rdata;

  assign take = link.req && !link.ack;
  assign wr = take && link.we;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.ack <= 1'b0;
    end else begin
      link.ack <= take;
    end
  end

  always_comb begin
    next_rdata = REG_RESET;
    unique case (link.addr)
      STATUS_ADDR: begin
        next_rdata[LOAD_PRESENT_BIT] = load_present;
        next_rdata[CHARGER_PRESENT_BIT] = charger_present;
      end
      MASK_ADDR: next_rdata = balance_output_mask;
      CONTROL1_ADDR: begin
        next_rdata[DISCHARGE_ON_BIT] = discharge_switch_on;
        next_rdata[LOAD_TRIG_BIT] = load_monitor_trigger;
        next_rdata[CHARGER_TRIG_BIT] = charger_monitor_trigger;
      end
      OVERRIDE_ADDR: begin
        next_rdata[SWITCH_OVR_BIT] = host_switch_override;
        next_rdata[BALANCE_OVR_BIT] = host_balance_override;
        next_rdata[LOAD_OVR_BIT] = host_load_monitor_override;
        next_rdata[CHARGER_OVR_BIT] = host_charger_monitor_override;
        next_rdata[SCAN_OVR_BIT] = host_scan_override;
        next_rdata[OW_TRIG_BIT] = open_wire_scan_trigger;
        next_rdata[BALANCE_APPLY_BIT] = balance_apply;
      end
      OW_CONFIG_ADDR: next_rdata[OW_DISABLE_BIT] = open_wire_detect_disable;
      default: next_rdata = REG_RESET;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.rdata <= REG_RESET;
    end else if (take) begin
      link.rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // discharge switch
  // ----------------------------------------
  // a fault clearing the bit beats a host write in the same cycle: safety first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      discharge_switch_on <= 1'b0;
    end else if (discharge_short_circuit) begin
      discharge_switch_on <= 1'b0;
    end else if (discharge_overcurrent && !host_switch_override) begin
      discharge_switch_on <= 1'b0;
    end else if (wr && link.addr == CONTROL1_ADDR) begin
      discharge_switch_on <= link.wdata[DISCHARGE_ON_BIT];
    end
  end

  assign forced_off = discharge_short_circuit || open_wire_fault || internal_over_temp
    || overvoltage_lockout || undervoltage_lockout || sleep_mode
    || switches_off_input;
  assign discharge_switch_gate = discharge_switch_on && !forced_off;
  assign auto_switch_enable = !host_switch_override;

  // ----------------------------------------
  // override register
  // ----------------------------------------
  // reserved top bit is never stored, so it always reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_switch_override <= 1'b0;
      host_balance_override <= 1'b0;
      host_load_monitor_override <= 1'b0;
      host_charger_monitor_override <= 1'b0;
      balance_apply <= 1'b0;
    end else if (wr && link.addr == OVERRIDE_ADDR) begin
      host_switch_override <= link.wdata[SWITCH_OVR_BIT];
      host_balance_override <= link.wdata[BALANCE_OVR_BIT];
      host_load_monitor_override <= link.wdata[LOAD_OVR_BIT];
      host_charger_monitor_override <= link.wdata[CHARGER_OVR_BIT];
      balance_apply <= link.wdata[BALANCE_APPLY_BIT];
    end
  end

  // watchdog expiry wins over a write landing in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_scan_override <= 1'b0;
    end else if (watchdog_expired) begin
      host_scan_override <= 1'b0;
    end else if (wr && link.addr == OVERRIDE_ADDR) begin
      host_scan_override <= link.wdata[SCAN_OVR_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_hold <= 1'b0;
    end else if (watchdog_expired) begin
      scan_hold <= 1'b1;
    end else if (take) begin
      scan_hold <= 1'b0;
    end
  end

  assign auto_scan_enable = !host_scan_override && !scan_hold;
  assign auto_balance_enable = !host_balance_override;
  assign auto_load_monitor_enable = !host_load_monitor_override;
  assign auto_charger_monitor_enable = !host_charger_monitor_override;

  // ----------------------------------------
  // open-wire scan
  // ----------------------------------------
  assign ow_set = wr && link.addr == OVERRIDE_ADDR && link.wdata[OW_TRIG_BIT]
    && (open_wire_detect_disable || host_scan_override);

  // a new start wins over a completion in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_wire_scan_trigger <= 1'b0;
    end else if (ow_set) begin
      open_wire_scan_trigger <= 1'b1;
    end else if (open_wire_scan_done) begin
      open_wire_scan_trigger <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_wire_scan_start <= 1'b0;
    end else begin
      open_wire_scan_start <= ow_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_wire_detect_disable <= 1'b0;
    end else if (wr && link.addr == OW_CONFIG_ADDR) begin
      open_wire_detect_disable <= link.wdata[OW_DISABLE_BIT];
    end
  end

  // ----------------------------------------
  // load and charger monitor triggers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_monitor_trigger <= 1'b0;
      load_recovery_pulse <= 1'b0;
    end else begin
      load_recovery_pulse <= load_monitor_trigger;
      if (wr && link.addr == CONTROL1_ADDR && link.wdata[LOAD_TRIG_BIT]
          && host_load_monitor_override) begin
        load_monitor_trigger <= 1'b1;
      end else begin
        load_monitor_trigger <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charger_monitor_trigger <= 1'b0;
      charger_recovery_pulse <= 1'b0;
    end else begin
      charger_recovery_pulse <= charger_monitor_trigger;
      if (wr && link.addr == CONTROL1_ADDR && link.wdata[CHARGER_TRIG_BIT]
          && host_charger_monitor_override) begin
        charger_monitor_trigger <= 1'b1;
      end else begin
        charger_monitor_trigger <= 1'b0;
      end
    end
  end

  // status sampled while the recovery pulse is out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_present <= 1'b0;
      charger_present <= 1'b0;
    end else begin
      if (load_recovery_pulse) begin
        load_present <= load_detect_pin;
      end
      if (charger_recovery_pulse) begin
        charger_present <= charger_detect_pin;
      end
    end
  end

  // ----------------------------------------
  // balance outputs and mask
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      balance_output_mask <= REG_RESET;
    end else if (wr && link.addr == MASK_ADDR) begin
      balance_output_mask <= link.wdata;
    end
  end

  for (genvar i = 0; i < BAL_CELLS; i++) begin : gen_bal
    assign balance_gate_outputs[i] = host_balance_override && balance_apply
      && balance_output_mask[i];
  end
endmodule : pack_override_monitor

// file: logic/pack_override_host.sv
// host end: axi4-lite command registers driving the monitor link
`timescale 1ns/100ps
module pack_override_host
  import pack_override_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  pack_link_if.host link
);
  // ----------------------------------------
  // axi write side
  // ----------------------------------------
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic do_write;
  logic start;

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;
  // a command written while the link is busy is dropped; poll busy first
  assign start = do_write && aw_addr == CMD_OFFSET && !link.req;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data <= wdata;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= (aw_addr == CMD_OFFSET) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // link transaction
  // ----------------------------------------
  logic [7:0] last_rdata;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.req <= 1'b0;
      link.we <= 1'b0;
      link.addr <= REG_RESET;
      link.wdata <= REG_RESET;
    end else if (start) begin
      link.req <= 1'b1;
      link.we <= w_data[CMD_WRITE_BIT];
      link.addr <= w_data[7:0];
      if (w_data[7:0] == OVERRIDE_ADDR) begin
        link.wdata <= w_data[15:8] & ~RESERVED_MASK;
      end else begin
        link.wdata <= w_data[15:8];
      end
    end else if (link.ack) begin
      link.req <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_rdata <= REG_RESET;
    end else if (link.req && link.ack && !link.we) begin
      last_rdata <= link.rdata;
    end
  end

  // ----------------------------------------
  // axi read side
  // ----------------------------------------
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
      unique case (araddr)
        STAT_OFFSET: rdata <= {16'h0, last_rdata, 7'h0, link.req};
        CMD_OFFSET: rdata <= {15'h0, link.we, link.wdata, link.addr};
        default: rresp <= RESP_SLVERR;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : pack_override_host

// file: verif/pack_link_properties.sv
// protocol checker for the host-to-monitor register link
`timescale 1ns/100ps
module pack_link_properties
  import pack_override_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // handshake
  // ----
  logic take;
  assign take = req && !ack;
  a_ack_after_take: assert property (take |=> ack)
    else $error("ack missing after take");
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_no_stray_ack: assert property (!req |=> !ack)
    else $error("ack without request");
  a_req_drops: assert property (ack |=> !req)
    else $error("req held after ack");
  a_cmd_stable: assert property (take |=> req && $stable({we, addr, wdata}))
    else $error("command changed before ack");
  // read byte must stand for the cycle after ack, though the host latches it at the end of the ack cycle
  a_rdata_holds: assert property (ack |=> $stable(rdata))
    else $error("read byte changed after ack");
  a_rsv_write_zero: assert property (
    req && we && addr == OVERRIDE_ADDR |-> !wdata[RESERVED_BIT])
    else $error("reserved bit written as one");
  a_rsv_read_zero: assert property (
    take && !we && addr == OVERRIDE_ADDR |=> !rdata[RESERVED_BIT])
    else $error("reserved bit read as one");
  cover property (take && we && addr == OVERRIDE_ADDR);
  cover property (take && !we && addr == STATUS_ADDR);
  cover property (take && we && addr == CONTROL1_ADDR);
endmodule : pack_link_properties

// file: verif/tb.sv
// bench: axi master on the host end, fault stimulus and pin watch on the monitor end
`timescale 1ns/100ps
module tb
  import pack_override_pkg::*;
;
  typedef struct {int kind; logic [33:0] exp;} note_t;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [3:0] awaddr = '0;
  logic [3:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] ev = '0;
  logic [5:0] frc = '0;
  logic ldp = '0, chp = '0, snap = '0;
  logic dgate, aswi, abal, aload, achg, ascan, ow_p, ld_p, ch_p;
  logic [7:0] bal, movr, mmask, d;
  logic [7:0] n_ow = '0, n_ld = '0, n_ch = '0;
  logic [31:0] r;
  int num_errors = 0, n_tests = 0, i;
  string nm[4] = '{"read", "pins", "pulses", "bresp"};
  note_t q[$];
  pack_link_if lnk();
  pack_override_host u_pack_override_host (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(lnk));
  pack_override_monitor #(.BAL_CELLS(8)) u_pack_override_monitor (.aclk(aclk),
    .aresetn(aresetn), .link(lnk), .discharge_overcurrent(ev[0]),
    .discharge_short_circuit(ev[1]), .open_wire_fault(frc[0]), .internal_over_temp(frc[1]),
    .overvoltage_lockout(frc[2]), .undervoltage_lockout(frc[3]), .sleep_mode(frc[4]),
    .switches_off_input(frc[5]), .watchdog_expired(ev[2]), .open_wire_scan_done(ev[3]),
    .load_detect_pin(ldp), .charger_detect_pin(chp), .discharge_switch_gate(dgate),
    .auto_switch_enable(aswi), .auto_balance_enable(abal), .auto_load_monitor_enable(aload),
    .auto_charger_monitor_enable(achg), .auto_scan_enable(ascan),
    .open_wire_scan_start(ow_p), .load_recovery_pulse(ld_p),
    .charger_recovery_pulse(ch_p), .balance_gate_outputs(bal));
  pack_link_properties u_pack_link_properties (.aclk(aclk), .aresetn(aresetn),
    .req(lnk.req), .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack),
    .rdata(lnk.rdata));
  // ----
  // clock, pulse counters, result watcher
  // ----
  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) begin
    if (ow_p) n_ow <= n_ow + 8'h1;
    if (ld_p) n_ld <= n_ld + 8'h1;
    if (ch_p) n_ch <= n_ch + 8'h1;
  end
  always @(posedge aclk) begin
    if ((rvalid && rready) || (bvalid && bready) || snap) begin
      note_t n;
      logic [33:0] got;
      n = q.pop_front();
      got = n.kind == 0 ? {rresp, rdata} : n.kind == 3 ? {32'h0, bresp} :
        n.kind == 1 ? {20'h0, dgate, aswi, abal, aload, achg, ascan, bal} :
        {10'h0, n_ow, n_ld, n_ch};
      n_tests++;
      if (got !== n.exp) begin
        num_errors++;
        $display("unexpected %0s: expected %h, seen %h", nm[n.kind], n.exp, got);
      end
    end
  end
  // ----
  // drivers
  // ----
  task automatic axw(input logic [3:0] a, input logic [31:0] v, input logic [1:0] e);
    q.push_back('{3, {32'h0, e}});
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
  endtask : axw
  task automatic axr(input logic [3:0] a, input logic [33:0] e);
    q.push_back('{0, e});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    // a back-to-back read must not raise rready in the step that lowered it
    @(posedge aclk);
  endtask : axr
  // link completion is read off the wire, the status word would cost a read per poll
  task automatic mw(input logic [7:0] a, input logic [7:0] v);
    axw(CMD_OFFSET, {15'h0, 1'h1, v, a}, RESP_OKAY);
    do @(posedge aclk); while (lnk.req);
  endtask : mw
  task automatic mr(input logic [7:0] a, input logic [7:0] e);
    axw(CMD_OFFSET, {24'h0, a}, RESP_OKAY);
    do @(posedge aclk); while (lnk.req);
    axr(STAT_OFFSET, {RESP_OKAY, 16'h0, e, 8'h0});
  endtask : mr
  task automatic look(input int k, input logic [33:0] e);
    q.push_back('{k, e});
    snap <= 1'h1;
    @(posedge aclk);
    snap <= 1'h0;
    @(posedge aclk);
  endtask : look
  task automatic lp(input logic g, input logic s);
    look(1, {20'h0, g, ~movr[6], ~movr[5], ~movr[4], ~movr[3], s,
      (movr[5] && movr[0]) ? mmask : 8'h0});
  endtask : lp
  task automatic hit(input int k);
    ev <= 4'h1 << k;
    @(posedge aclk);
    ev <= 4'h0;
    @(posedge aclk);
  endtask : hit
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    print_verdict();
  end
  // ----
  // tests
  // ----
  initial begin
    void'($urandom(6989));
    movr = '0;
    mmask = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    lp(1'h0, 1'h1);
    mr(OVERRIDE_ADDR, REG_RESET);
    mw(CONTROL1_ADDR, 8'h01);
    lp(1'h1, 1'h1);
    hit(0);
    mr(CONTROL1_ADDR, 8'h00);
    $display("done: switch bit");
    movr = 8'h40;
    mw(OVERRIDE_ADDR, movr);
    mw(CONTROL1_ADDR, 8'h01);
    hit(0);
    lp(1'h1, 1'h1);
    for (i = 0; i < 6; i++) begin
      frc <= 6'h1 << i;
      lp(1'h0, 1'h1);
    end
    frc <= '0;
    lp(1'h1, 1'h1);
    hit(1);
    lp(1'h0, 1'h1);
    mr(CONTROL1_ADDR, 8'h00);
    $display("done: forced off");
    mmask = 8'($urandom);
    mw(MASK_ADDR, mmask);
    for (i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'ha1 : 8'($urandom) & 8'hfd;
      movr = d & 8'h7d;
      mw(OVERRIDE_ADDR, d);
      lp(1'h0, ~movr[2]);
      mr(OVERRIDE_ADDR, movr);
    end
    $display("done: overrides");
    movr = '0;
    // a scan override left by the random loop would arm the trigger
    mw(OVERRIDE_ADDR, 8'h00);
    mw(OVERRIDE_ADDR, 8'h02);
    mr(OVERRIDE_ADDR, 8'h00);
    look(2, 34'h0);
    mw(OW_CONFIG_ADDR, 8'h02);
    mw(OVERRIDE_ADDR, 8'h02);
    mr(OVERRIDE_ADDR, 8'h02);
    hit(3);
    mr(OVERRIDE_ADDR, 8'h00);
    mw(OW_CONFIG_ADDR, 8'h00);
    mw(OVERRIDE_ADDR, 8'h04);
    mw(OVERRIDE_ADDR, 8'h06);
    hit(3);
    look(2, {10'h0, 8'h2, 16'h0});
    $display("done: open wire");
    movr = 8'h04;
    lp(1'h0, 1'h0);
    hit(2);
    movr = '0;
    lp(1'h0, 1'h0);
    mr(OVERRIDE_ADDR, 8'h00);
    lp(1'h0, 1'h1);
    $display("done: watchdog");
    r = $urandom;
    ldp <= r[0];
    chp <= r[1];
    mw(OVERRIDE_ADDR, 8'h18);
    mw(CONTROL1_ADDR, 8'h40);
    mw(CONTROL1_ADDR, 8'h10);
    mr(CONTROL1_ADDR, 8'h00);
    mr(STATUS_ADDR, {6'h0, r[1], r[0]});
    look(2, {10'h0, 8'h2, 8'h1, 8'h1});
    $display("done: monitor triggers");
    axw(4'h8, 32'h0, RESP_SLVERR);
    axr(4'h8, {RESP_SLVERR, 32'h0});
    axr(CMD_OFFSET, {RESP_OKAY, 24'h0, STATUS_ADDR});
    $display("done: axi map");
    print_verdict();
  end
endmodule : tb
